// ---- src/pcs_control_status.sv ----
// Purpose: register bank and pin decode of the preamp control and status
// Assumes: register accesses arrive already deserialised, one strobe a word
// Notes: analog converter and fault detectors sit outside this block
module pcs_control_status (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire pcs_pkg::pcs_pins_s pinIn,
  input wire logic tacOn,
  input wire logic [pcs_pkg::FAULT_N-1:0] faultDetect,
  input wire logic convReady,
  input wire logic [4:0] convCode,
  output logic convStart,
  output logic [1:0] convRange,
  output logic faultOut,
  output logic faultSink,
  output logic writeInhibit,
  output logic readerBiasOff,
  output logic passbandRaise,
  output logic dummyHeadSelect,
  output pcs_pkg::pcs_power_e powerMode,
  output logic compTcSel,
  output logic [2:0] compThresh,
  output logic sdataLevel5v
);
  import pcs_pkg::*;

  pcs_meas_s meas_ff;
  pcs_mode_s mode_ff;
  pcs_comp_s comp_ff;
  pcs_fault_s fault_ff;
  pcs_test_s test_ff;
  pcs_conv_e conv_ff;
  pcs_power_e power_ff;
  logic trigPrev_ff;
  logic convStart_ff;
  logic [1:0] convRange_ff;
  logic faultOut_ff;
  logic faultSink_ff;
  logic inhibit_ff;
  logic biasOff_ff;
  logic band_ff;
  logic dummyHead_ff;
  logic [7:0] rdata_ff;
  logic [PIN_W-1:0] s1_ff;
  logic [PIN_W-1:0] s2_ff;
  logic [PIN_W-1:0] s3_ff;
  logic [PIN_W-1:0] stable_ff;
  pcs_pins_s pins;
  logic [FAULT_N-1:0] maskVec;
  logic [FAULT_N-1:0] reported;
  logic [3:0] nxt_code;
  logic dummyCmd;
  logic regClear;
  logic wrMeas;
  logic wrMode;
  logic wrComp;
  logic wrFault;
  logic wrTest;
  logic forbidden;
  logic stwActive;
  logic trigRise;
  logic trigFall;
  logic funcSel;

  // pin synchronisers, a change counts once stages two and three agree
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        s1_ff[i] <= PIN_RST[i];
        s2_ff[i] <= PIN_RST[i];
        s3_ff[i] <= PIN_RST[i];
        stable_ff[i] <= PIN_RST[i];
      end else begin
        s1_ff[i] <= pinIn[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          stable_ff[i] <= s3_ff[i];
        end
      end
    end
  end
  assign pins = stable_ff;

  // register decode
  assign dummyCmd = !mode_ff.rstFn && !pins.dummyReset;
  assign regClear = reset || dummyCmd;
  assign forbidden = pins.chipSel == CS_BROADCAST && pins.servoWriteN;
  assign wrMeas = regWrite && regAddr == OFS_MEAS;
  assign wrMode = regWrite && regAddr == OFS_MODE;
  assign wrComp = regWrite && regAddr == OFS_COMP;
  assign wrFault = regWrite && regAddr == OFS_FAULT;
  assign wrTest = regWrite && regAddr == OFS_TEST;
  assign trigRise = meas_ff.trig && !trigPrev_ff;
  assign trigFall = !meas_ff.trig && trigPrev_ff;

  // measurement register, result field loaded only by the converter and cleared on trigger fall
  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      meas_ff <= MEAS_RST;
    end else begin
      if (wrMeas) begin
        meas_ff.trig <= regWdata[7];
        meas_ff.sel <= regWdata[6:5];
      end
      if (trigFall) begin
        meas_ff.code <= 5'h00;
      end else if (conv_ff == CONV_BUSY && convReady) begin
        meas_ff.code <= convCode;
      end
    end
  end

  // conversion sequencing
  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      conv_ff <= CONV_IDLE;
      trigPrev_ff <= 1'b0;
      convStart_ff <= 1'b0;
      convRange_ff <= SEL_LOW_RANGE;
    end else begin
      trigPrev_ff <= meas_ff.trig;
      convStart_ff <= 1'b0;
      case (conv_ff)
        CONV_IDLE: begin
          if (trigRise) begin
            conv_ff <= CONV_BUSY;
            convStart_ff <= 1'b1;
            convRange_ff <= meas_ff.sel;
          end
        end
        CONV_BUSY: begin
          if (trigFall) begin
            conv_ff <= CONV_IDLE;
          end else if (convReady) begin
            conv_ff <= CONV_HOLD;
          end
        end
        CONV_HOLD: begin
          if (trigFall) begin
            conv_ff <= CONV_IDLE;
          end
        end
        default: begin
          conv_ff <= CONV_IDLE;
        end
      endcase
    end
  end

  // operating mode register, writes refused in the forbidden pin state
  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      mode_ff <= MODE_RST;
    end else if (wrMode && !forbidden) begin
      mode_ff.level <= regWdata[0];
      mode_ff.rstFn <= regWdata[1];
      mode_ff.power <= regWdata[3:2];
    end
  end

  // compression register
  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      comp_ff <= COMP_RST;
    end else if (wrComp) begin
      comp_ff.gate <= regWdata[0];
      comp_ff.tcSel <= regWdata[1];
      comp_ff.thresh <= regWdata[4:2];
      comp_ff.rsv[2] <= regWdata[7];
    end
  end

  // fault mask per class: code i+1 silences class i, all-ones silences all
  for (genvar i = 0; i < FAULT_N; i++) begin : g_mask
    assign maskVec[i] = fault_ff.mask == MASK_ALL || fault_ff.mask == 3'(i + 1);
  end
  assign reported = faultDetect & ~maskVec;

  always_comb begin
    nxt_code = 4'h0;
    for (int i = FAULT_N - 1; i >= 0; i--) begin
      if (reported[i]) begin
        nxt_code = 4'(i + 1);
      end
    end
  end

  // fault register, a new fault wins over a clearing mode write
  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      fault_ff <= FAULT_RST;
    end else begin
      if (wrFault) begin
        fault_ff.mask <= regWdata[2:0];
      end
      if (|reported && fault_ff.code == 4'h0) begin
        fault_ff.code <= nxt_code;
      end else if (wrMode) begin
        fault_ff.code <= 4'h0;
      end
    end
  end

  // fault line level and linked protection
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      faultOut_ff <= 1'b1;
      inhibit_ff <= 1'b0;
    end else begin
      faultOut_ff <= |reported ? pins.writeMode : !pins.writeMode;
      inhibit_ff <= faultDetect[0];
    end
  end

  // multiple-device-selected check
  assign stwActive = power_ff == PWR_STW_ONE || power_ff == PWR_STW_TWO;
  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      test_ff <= TEST_RST;
      faultSink_ff <= 1'b0;
    end else begin
      if (wrTest) begin
        test_ff.enable <= regWdata[0];
      end
      faultSink_ff <= test_ff.enable && !stwActive;
      test_ff.flag <= test_ff.enable && !stwActive && pins.faultLineLow;
    end
  end

  // power mode decode
  always_ff @(posedge sys_clk) begin
    if (regClear) begin
      power_ff <= PWR_SLEEP;
    end else if (pins.servoWriteN) begin
      case (mode_ff.power)
        PM_SLEEP: power_ff <= PWR_SLEEP;
        PM_STANDBY: power_ff <= PWR_STANDBY;
        PM_ACTIVE: power_ff <= PWR_ACTIVE;
        default: power_ff <= PWR_TEST;
      endcase
    end else if (pins.chipSel == CS_BROADCAST && mode_ff.power == PM_ACTIVE) begin
      power_ff <= PWR_STW_ONE;
    end else if (pins.chipSel == CS_BROADCAST && mode_ff.power == PM_TEST) begin
      power_ff <= PWR_STW_TWO;
    end else begin
      power_ff <= PWR_SLEEP;
    end
  end

  // fast recovery and dummy reset pin decode
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      biasOff_ff <= 1'b0;
      band_ff <= 1'b0;
      dummyHead_ff <= 1'b0;
    end else begin
      biasOff_ff <= pins.writeMode && pins.fastRecovery && !funcSel;
      band_ff <= funcSel && pins.fastRecovery && (!tacOn || comp_ff.gate);
      dummyHead_ff <= mode_ff.rstFn && pins.dummyReset && !pins.writeMode;
    end
  end

  // pin function select sits in the top bit of the compression register
  assign funcSel = comp_ff.rsv[2];

  // read back, unmapped indices read zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else begin
      case (regAddr)
        OFS_MEAS: rdata_ff <= meas_ff;
        OFS_MODE: rdata_ff <= mode_ff;
        OFS_COMP: rdata_ff <= comp_ff;
        OFS_FAULT: rdata_ff <= fault_ff;
        OFS_TEST: rdata_ff <= test_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign regRdata = rdata_ff;
  assign convStart = convStart_ff;
  assign convRange = convRange_ff;
  assign faultOut = faultOut_ff;
  assign faultSink = faultSink_ff;
  assign writeInhibit = inhibit_ff;
  assign readerBiasOff = biasOff_ff;
  assign passbandRaise = band_ff;
  assign dummyHeadSelect = dummyHead_ff;
  assign powerMode = power_ff;
  assign compTcSel = comp_ff.tcSel;
  assign compThresh = comp_ff.thresh;
  assign sdataLevel5v = mode_ff.level;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (regClear);

  sequence s_trig_rise;
    $rose(meas_ff.trig) && conv_ff == CONV_IDLE;
  endsequence
  sequence s_result_held;
    conv_ff == CONV_HOLD && meas_ff.trig && !trigFall;
  endsequence

  a_conv_start_edge: assert property (s_trig_rise |=> convStart && convRange == $past(meas_ff.sel))
    else $error("conversion not started on trigger rise");
  a_conv_no_start: assert property (!trigRise |=> !convStart)
    else $error("conversion started without trigger rise");
  a_result_hold: assert property (s_result_held |=> $stable(meas_ff.code))
    else $error("result changed while trigger high");
  a_result_clear: assert property (trigFall |=> meas_ff.code == 5'h00)
    else $error("result not cleared on trigger fall");
  a_fault_level: assert property (|reported |=> faultOut == $past(pins.writeMode))
    else $error("fault line wrong level for mode");
  a_fault_release: assert property (!(|reported) |=> faultOut != $past(pins.writeMode))
    else $error("fault line held without fault");
  a_fault_latch: assert property (|reported && fault_ff.code == 4'h0 |=> fault_ff.code == $past(nxt_code))
    else $error("fault code not latched");
  a_code_clear: assert property (wrMode && !(|reported) |=> fault_ff.code == 4'h0)
    else $error("mode write did not clear fault code");
  a_mask_silent: assert property (fault_ff.mask == MASK_ALL && fault_ff.code == 4'h0 |=> fault_ff.code == 4'h0)
    else $error("masked fault latched a code");
  a_mask_line: assert property (fault_ff.mask == MASK_ALL |=> faultOut != $past(pins.writeMode))
    else $error("masked fault toggled the fault line");
  a_band_pin: assert property (!pins.fastRecovery |=> !passbandRaise)
    else $error("passband raised with pin low");
  a_bias_func: assert property (funcSel |=> !readerBiasOff)
    else $error("reader bias switched with passband function");
  a_band_gate: assert property (tacOn && !comp_ff.gate |=> !passbandRaise)
    else $error("pin drove passband while inhibited");
  a_multi_flag: assert property (!test_ff.enable |=> !test_ff.flag)
    else $error("multi-select flag set with test off");
  a_mode_forbid: assert property (wrMode && forbidden |=> $stable(mode_ff))
    else $error("mode written in forbidden pin state");
  a_dummy_clear: assert property (@(posedge sys_clk) disable iff (reset) dummyCmd |=> meas_ff == MEAS_RST)
    else $error("dummy reset did not clear registers");
endmodule

// ---- src/pcs_pkg.sv ----
// Purpose: constants and types for the preamp control and status block
// Assumes: decoded serial register port, 4-bit register index, 8-bit data
// Notes: field layouts are given by the packed register structs
package pcs_pkg;
  localparam logic [3:0] OFS_FAULT = 4'h7;
  localparam logic [3:0] OFS_MEAS = 4'h8;
  localparam logic [3:0] OFS_MODE = 4'h9;
  localparam logic [3:0] OFS_COMP = 4'hb;
  localparam logic [3:0] OFS_TEST = 4'hc;
  localparam int PIN_W = 7;
  localparam int FAULT_N = 6;
  localparam logic [1:0] SEL_LOW_RANGE = 2'h0;
  localparam logic [1:0] SEL_TEMP = 2'h3;
  localparam logic TC_SEL_700NS = 1'b0;
  localparam logic TC_SEL_70NS = 1'b1;
  localparam logic [2:0] THRESH_4P00MV = 3'h0;
  localparam logic [2:0] THRESH_0P50MV = 3'h7;
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [2:0] MASK_ALL = 3'h7;
  localparam logic [1:0] CS_BROADCAST = 2'h3;
  localparam logic [1:0] PM_SLEEP = 2'h0;
  localparam logic [1:0] PM_STANDBY = 2'h1;
  localparam logic [1:0] PM_ACTIVE = 2'h2;
  localparam logic [1:0] PM_TEST = 2'h3;
  typedef enum logic [2:0] {PWR_SLEEP, PWR_STANDBY, PWR_ACTIVE, PWR_TEST, PWR_STW_ONE, PWR_STW_TWO} pcs_power_e;
  typedef enum logic [1:0] {CONV_IDLE, CONV_BUSY, CONV_HOLD} pcs_conv_e;
  typedef struct packed {logic trig; logic [1:0] sel; logic [4:0] code;} pcs_meas_s;
  typedef struct packed {logic [3:0] rsv; logic [1:0] power; logic rstFn; logic level;} pcs_mode_s;
  typedef struct packed {logic [2:0] rsv; logic [2:0] thresh; logic tcSel; logic gate;} pcs_comp_s;
  typedef struct packed {logic rsv; logic [3:0] code; logic [2:0] mask;} pcs_fault_s;
  typedef struct packed {logic [5:0] rsv; logic flag; logic enable;} pcs_test_s;
  typedef struct packed {
    logic writeMode;
    logic faultLineLow;
    logic [1:0] chipSel;
    logic servoWriteN;
    logic dummyReset;
    logic fastRecovery;
  } pcs_pins_s;
  localparam pcs_meas_s MEAS_RST = '0;
  localparam pcs_mode_s MODE_RST = '0;
  localparam pcs_comp_s COMP_RST = '0;
  localparam pcs_fault_s FAULT_RST = '0;
  localparam pcs_test_s TEST_RST = '0;
  localparam logic [PIN_W-1:0] PIN_RST = 7'h48;
endpackage

// ---- verif/pcs_conv_model.sv ----
// Purpose: converter partner answering conversion launches
// Assumes: one launch at a time, answer delay plus one cycles after the launch
// Notes: code lines toggle every cycle when not answering
module pcs_conv_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic convStart,
  input wire logic [7:0] delay,
  input wire logic [4:0] code,
  output logic convReady,
  output logic [4:0] convCode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic busy_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      convReady <= 1'b0;
      convCode <= 5'h0a;
    end else begin
      convReady <= 1'b0;
      convCode <= ~convCode;
      if (convStart) begin
        busy_ff <= 1'b1;
        cnt_ff <= delay;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
        convReady <= 1'b1;
        convCode <= code;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

// ---- verif/pcs_control_status_bench.sv ----
// Purpose: self-checking bench of the preamp control and status block
// Assumes: pins settle within six cycles of a change
// Notes: register table rows first, then conversions, faults and pins
module pcs_control_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} pcs_row_s;
  pcs_row_s rows [6] = '{'{4'h9, 8'hff, 8'h0f}, '{4'hb, 8'hff, 8'h9f}, '{4'h7, 8'hff, 8'h07},
    '{4'hc, 8'hfe, 8'h00}, '{4'h8, 8'h7f, 8'h60}, '{4'h0, 8'hff, 8'h00}};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic regWrite = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  pcs_pins_s pinIn = 7'h06;
  logic tacOn = 1'b0;
  logic [5:0] faultDetect = 6'h00;
  logic convReady, convStart, faultOut, faultSink, writeInhibit, readerBiasOff;
  logic passbandRaise, dummyHeadSelect, compTcSel, sdataLevel5v;
  logic [4:0] convCode;
  logic [4:0] mCode = 5'h00;
  logic [7:0] mDelay = 8'h00;
  logic [7:0] exp;
  logic [1:0] convRange;
  logic [2:0] compThresh;
  pcs_power_e powerMode;
  int mismatches = 0;
  int n_tests = 0;
  int starts = 0;
  int i;
  pcs_control_status DUT (.sys_clk(sys_clk), .reset(reset), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .pinIn(pinIn), .tacOn(tacOn), .faultDetect(faultDetect),
    .convReady(convReady), .convCode(convCode), .convStart(convStart), .convRange(convRange),
    .faultOut(faultOut), .faultSink(faultSink), .writeInhibit(writeInhibit), .readerBiasOff(readerBiasOff),
    .passbandRaise(passbandRaise), .dummyHeadSelect(dummyHeadSelect), .powerMode(powerMode),
    .compTcSel(compTcSel), .compThresh(compThresh), .sdataLevel5v(sdataLevel5v));
  pcs_conv_model conv (.sys_clk(sys_clk), .reset(reset), .convStart(convStart), .delay(mDelay),
    .code(mCode), .convReady(convReady), .convCode(convCode));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (convStart === 1'b1) starts++;
  end
  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("[FAIL] wait expected done seen timeout");
    report_and_stop();
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge sys_clk);
    regWrite = 1'b0;
  endtask
  task automatic rdq(input logic [3:0] a);
    @(negedge sys_clk);
    regAddr = a;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    rdq(a);
    chk(n, e, regRdata);
  endtask
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    settle();
    chk("faultOut reset", 8'h01, faultOut);
    foreach (rows[k]) rd(rows[k].a, 8'h00, "reset value");
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a, rows[k].e, "readback");
    end
    chk("thresh", {5'h00, THRESH_0P50MV}, compThresh);
    chk("tcSel", {7'h00, TC_SEL_70NS}, compTcSel);
    chk("level", 8'h01, sdataLevel5v);
    chk("passband", 8'h00, passbandRaise);
    wr(OFS_COMP, 8'h00);
    chk("thresh low", {5'h00, THRESH_4P00MV}, compThresh);
    chk("tcSel low", {7'h00, TC_SEL_700NS}, compTcSel);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_MODE, 8'(p * 4 + 2));
      @(negedge sys_clk);
      chk("power", 8'(p), 8'(powerMode));
    end
    chk("dummy head", 8'h01, dummyHeadSelect);
    pinIn.chipSel = CS_BROADCAST;
    settle();
    wr(OFS_MODE, 8'h00);
    rd(OFS_MODE, 8'h0e, "forbidden mode");
    pinIn.chipSel = 2'h0;
    for (int s = 0; s < 4; s++) begin
      mDelay = 8'(s * 13 + 1);
      mCode = 5'(s * 7 + 3);
      exp = {1'b1, 2'(s), mCode};
      wr(OFS_MEAS, {1'b1, 2'(s), 5'h1f});
      for (i = 0; i < 20 && starts != s + 1; i++) @(negedge sys_clk);
      if (i == 20) timeout();
      chk("range", 8'(s), 8'(convRange));
      for (i = 0; i < 100 && regRdata !== exp; i++) rdq(OFS_MEAS);
      if (i == 100) timeout();
      wr(OFS_MEAS, {1'b1, 2'(s), 5'h00});
      repeat (4) @(negedge sys_clk);
      chk("no restart", 8'(s + 1), 8'(starts));
      rd(OFS_MEAS, exp, "result held");
      wr(OFS_MEAS, {1'b0, 2'(s), 5'h00});
      rd(OFS_MEAS, {1'b0, 2'(s), 5'h00}, "result cleared");
    end
    wr(OFS_FAULT, 8'h00);
    faultDetect = 6'h06;
    repeat (2) @(negedge sys_clk);
    chk("fault read", 8'h00, faultOut);
    faultDetect = 6'h00;
    repeat (2) @(negedge sys_clk);
    chk("fault gone", 8'h01, faultOut);
    rd(OFS_FAULT, 8'h10, "fault code");
    wr(OFS_FAULT, 8'h07);
    rd(OFS_FAULT, 8'h17, "code write");
    wr(OFS_MODE, 8'h0a);
    rd(OFS_FAULT, 8'h07, "code clear");
    for (int k = 1; k < 7; k++) begin
      wr(OFS_FAULT, 8'(k));
      faultDetect = 6'(1 << (k - 1));
      repeat (2) @(negedge sys_clk);
      chk("masked line", 8'h01, faultOut);
      if (k == 1) chk("inhibit", 8'h01, writeInhibit);
      rd(OFS_FAULT, 8'(k), "masked code");
      faultDetect = 6'h00;
    end
    wr(OFS_FAULT, {5'h00, MASK_ALL});
    faultDetect = 6'h3f;
    rd(OFS_FAULT, 8'h07, "mask all");
    chk("mask all line", 8'h01, faultOut);
    wr(OFS_FAULT, {5'h00, MASK_NONE});
    rd(OFS_FAULT, 8'h08, "lowest class");
    faultDetect = 6'h00;
    pinIn.writeMode = 1'b1;
    pinIn.fastRecovery = 1'b1;
    settle();
    chk("write idle", 8'h00, faultOut);
    chk("no dummy write", 8'h00, dummyHeadSelect);
    chk("bias off", 8'h01, readerBiasOff);
    faultDetect = 6'h04;
    repeat (2) @(negedge sys_clk);
    chk("fault write", 8'h01, faultOut);
    faultDetect = 6'h00;
    pinIn.fastRecovery = 1'b0;
    settle();
    chk("bias on", 8'h00, readerBiasOff);
    wr(OFS_TEST, 8'h01);
    pinIn.faultLineLow = 1'b1;
    settle();
    chk("sink", 8'h01, faultSink);
    rd(OFS_TEST, 8'h03, "multi flag");
    pinIn.faultLineLow = 1'b0;
    settle();
    rd(OFS_TEST, 8'h01, "single");
    pinIn.chipSel = CS_BROADCAST;
    pinIn.servoWriteN = 1'b0;
    settle();
    @(negedge sys_clk);
    chk("stw one", 8'(PWR_STW_ONE), 8'(powerMode));
    chk("sink stw", 8'h00, faultSink);
    wr(OFS_MODE, 8'h0e);
    @(negedge sys_clk);
    chk("stw two", 8'(PWR_STW_TWO), 8'(powerMode));
    pinIn.chipSel = 2'h0;
    pinIn.servoWriteN = 1'b1;
    wr(OFS_COMP, 8'h80);
    pinIn.fastRecovery = 1'b1;
    settle();
    chk("band raise", 8'h01, passbandRaise);
    chk("bias kept", 8'h00, readerBiasOff);
    tacOn = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("band gated", 8'h00, passbandRaise);
    wr(OFS_COMP, 8'h81);
    @(negedge sys_clk);
    chk("band enabled", 8'h01, passbandRaise);
    tacOn = 1'b0;
    pinIn.fastRecovery = 1'b0;
    settle();
    chk("band normal", 8'h00, passbandRaise);
    wr(OFS_MODE, 8'h08);
    wr(OFS_COMP, 8'h1f);
    pinIn.dummyReset = 1'b0;
    settle();
    rd(OFS_COMP, 8'h00, "pin clear");
    pinIn.dummyReset = 1'b1;
    settle();
    wr(OFS_COMP, 8'h1f);
    @(negedge sys_clk);
    reset = 1'b1;
    @(negedge sys_clk);
    reset = 1'b0;
    settle();
    rd(OFS_COMP, 8'h00, "second reset");
    report_and_stop();
  end
endmodule
